// >>> logic/tbc_board_ctrl.sv
// timing board control logic: straps, reinit, tick, steering, apb regs
// Function
// - pushbutton rising edge clears state and restarts initialisation.
// - everything runs from one system clock domain.
// - channel switch high selects dual output, low single full image.
// - binning switch high selects 2x2 binned single output, low none.
// - remote line high forces generator reset; its fall reinitialises.
// - exposure selection comes from remote bits eleven to seven only.
// - works with remote inputs unused; they only force reinit and tune exposure.
// - a 1 ms exposure tick is generated and driven on a pin.
// - exposure active output is high during the integration interval.
// - pixel, line and frame valid inputs are copied to monitor outputs.
// - timing generator outputs are tracked to keep sequencing in step.
// - one shared clock and data output, separate load strobe for fe1, fe2 and generator.
// - first three bits, msb first, select controller, fe1, fe2 or generator.
// - fourth bit is direction; only writes, so it is low.
// - both switches high gives single channel binning; binning wins.
// - the tick times a startup delay after any reset before programming.
`timescale 1ns/100ps
module tbc_board_ctrl
  import tbc_pkg::*;
#(
  parameter int TICK_CYCLES = TBC_TICK_CYCLES,
  parameter int DELAY_TICKS = TBC_PWR_DELAY_MS
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        boardResetBtn,
  input  wire logic        channelCountSwitch,
  input  wire logic        binningSwitch,
  input  wire logic        remoteReinitIn,
  input  wire logic [15:0] remoteDio,
  input  wire logic        hostLoadIn,
  input  wire logic        hostShiftClkIn,
  input  wire logic        hostSerialIn,
  input  wire logic        tgPixValidIn,
  input  wire logic        tgLineValidIn,
  input  wire logic        tgFrameValidIn,
  input  wire logic        tgIntStartIn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             tgForceResetN,
  output logic             exposureTickOut,
  output logic             exposureActiveOut,
  output logic             pixValidOut,
  output logic             lineValidOut,
  output logic             frameValidOut,
  output logic             frameSyncToTg,
  output logic             sharedShiftClkOut,
  output logic             sharedSerialOut,
  output logic             tgLoadStrobe,
  output logic [1:0]       frontendLoadStrobe
);
  localparam int          CW         = $clog2(TICK_CYCLES + 1);
  localparam int          DW         = $clog2(DELAY_TICKS + 1);
  localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);
  localparam logic [CW-1:0] TICK_HALF = CW'(TICK_CYCLES / 2);
  localparam logic [DW-1:0] DELAY_LAST = DW'(DELAY_TICKS - 1);
  localparam logic [1:0]  HDR_LAST   = 2'(TBC_HDR_BITS - 1);

  tbc_pins_t   pinRaw;
  tbc_pins_t   pin;
  tbc_pins_t   pinPrev_q;
  tbc_init_t   initSt_q;
  tbc_ser_t    serSt_q;
  tbc_mode_t   mode_q;
  tbc_status_t status;
  logic [CW-1:0]         tickCnt_q;
  logic [DW-1:0]         delayCnt_q;
  logic [4:0]            expSel_q;
  logic [1:0]            hdrCnt_q;
  logic [2:0]            hdr_q;
  logic [2:0]            tgt_q;
  logic                  clkArmed_q;
  logic [TBC_SELF_W-1:0] selfShift_q;
  logic [7:0]            frameCnt_q;
  logic                  steerEn_q;
  logic                  expose_q;

  // outside pins go through one synchroniser bank; bits 11..7 only
  assign pinRaw = '{boardReset: boardResetBtn, chanSw: channelCountSwitch,
                    binSw: binningSwitch, remoteReinit: remoteReinitIn,
                    expSel: remoteDio[11:7], hostLoad: hostLoadIn,
                    hostClk: hostShiftClkIn, hostData: hostSerialIn,
                    pixValid: tgPixValidIn, lineValid: tgLineValidIn,
                    frameValid: tgFrameValidIn,
                    intStart: tgIntStartIn};
  tbc_sync #(
    .W       ($bits(tbc_pins_t)),
    .RST_VAL (TBC_PINS_RST)
  ) uSync (
    .clock (clock),
    .rst_n (rst_n),
    .din   (pinRaw),
    .dout  (pin)
  );

  // edges are taken only on synchronised levels, so one pulse acts once
  wire btnRise    = pin.boardReset & ~pinPrev_q.boardReset;
  wire remoteFall = ~pin.remoteReinit & pinPrev_q.remoteReinit;
  wire loadFall   = ~pin.hostLoad & pinPrev_q.hostLoad;
  wire loadRise   = pin.hostLoad & ~pinPrev_q.hostLoad;
  wire clkRise    = pin.hostClk & ~pinPrev_q.hostClk;
  wire clkFall    = ~pin.hostClk & pinPrev_q.hostClk;
  wire intRise    = pin.intStart & ~pinPrev_q.intStart;
  wire frameRise  = pin.frameValid & ~pinPrev_q.frameValid;
  wire frameFall  = ~pin.frameValid & pinPrev_q.frameValid;

  // apb decode: one wait state, answer registered
  wire apbAccess  = psel & penable & ~pready;
  wire apbDone    = psel & penable & pready;
  wire regCtrl    = paddr == TBC_REG_CTRL;
  wire regStatus  = paddr == TBC_REG_STATUS;
  wire regSelf    = paddr == TBC_REG_SELF;
  wire mapped     = regCtrl | regStatus | regSelf;
  wire ctrlWrite  = apbDone & pwrite & regCtrl;
  wire softReinit = ctrlWrite & pwdata[TBC_CTRL_REINIT];
  // every reinit source funnels here
  wire reinit     = btnRise | remoteFall | softReinit;

  // tick and startup delay
  wire tickWrap  = tickCnt_q == TICK_LAST;
  wire inDelay   = initSt_q == TBC_INIT_DELAY;
  wire ready     = initSt_q == TBC_INIT_READY;
  wire delayDone = inDelay & tickWrap & (delayCnt_q == DELAY_LAST);
  // binning overrides dual output
  wire tbc_mode_t modeNext = pin.binSw  ? TBC_MODE_BIN :
                             pin.chanSw ? TBC_MODE_DUAL :
                                          TBC_MODE_SINGLE;

  // serial steering decode
  wire hdrLast  = hdrCnt_q == HDR_LAST;
  wire tgtKnown = hdr_q <= TBC_TGT_TG;
  wire inPass   = serSt_q == TBC_SER_PASS;
  wire fwd      = inPass & (tgt_q != TBC_TGT_SELF);
  wire selfBit  = inPass & (tgt_q == TBC_TGT_SELF) & clkRise;

  // read data mux
  assign status = '{frames: frameCnt_q, rsvd: '0, expose: expose_q,
                    ready: ready, expSel: expSel_q, mode: mode_q};
  wire [31:0] ctrlWord = 32'(steerEn_q) << TBC_CTRL_STEER_EN;
  wire [31:0] rdData   = regCtrl   ? ctrlWord :
                         regStatus ? 32'(status) :
                         regSelf   ? 32'(selfShift_q) : '0;

  // edge history of synchronised pins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) pinPrev_q <= TBC_PINS_RST;
    else        pinPrev_q <= pin;
  end

  // apb answer and control register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready    <= 1'h0;
      pslverr   <= 1'h0;
      prdata    <= '0;
      steerEn_q <= TBC_STEER_EN_RST;
    end else begin
      pready  <= apbAccess;
      pslverr <= apbAccess & ~mapped;
      prdata  <= apbAccess ? rdData : '0;
      if (ctrlWrite) steerEn_q <= pwdata[TBC_CTRL_STEER_EN];
    end
  end

  // 1 ms tick; a board reset restarts the count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_q       <= '0;
      exposureTickOut <= 1'h0;
    end else begin
      tickCnt_q       <= (reinit | tickWrap) ? '0 : tickCnt_q + 1'b1;
      exposureTickOut <= tickCnt_q < TICK_HALF;
    end
  end

  // startup delay in ticks, then switch settings are latched
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      initSt_q   <= TBC_INIT_DELAY;
      delayCnt_q <= '0;
      mode_q     <= TBC_MODE_SINGLE;
      expSel_q   <= '0;
    end else if (reinit) begin
      initSt_q   <= TBC_INIT_DELAY;
      delayCnt_q <= '0;
    end else begin
      case (initSt_q)
        TBC_INIT_DELAY: begin
          if (tickWrap) delayCnt_q <= delayCnt_q + 1'b1;
          if (delayDone) begin
            initSt_q <= TBC_INIT_READY;
            mode_q   <= modeNext;
            expSel_q <= pin.expSel;
          end
        end
        TBC_INIT_READY: initSt_q <= TBC_INIT_READY;
        default:        initSt_q <= TBC_INIT_DELAY;
      endcase
    end
  end

  // host frame: header bits first, then payload passes to the target
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      serSt_q  <= TBC_SER_IDLE;
      hdrCnt_q <= '0;
      hdr_q    <= '0;
      tgt_q    <= '0;
    end else if (reinit) begin
      serSt_q  <= TBC_SER_IDLE;
    end else begin
      case (serSt_q)
        TBC_SER_IDLE: begin
          if (loadFall & ready & steerEn_q) begin
            serSt_q  <= TBC_SER_HDR;
            hdrCnt_q <= '0;
          end
        end
        TBC_SER_HDR: begin
          if (loadRise) begin
            serSt_q <= TBC_SER_IDLE;
          end else if (clkRise) begin
            hdrCnt_q <= hdrCnt_q + 1'b1;
            if (!hdrLast) hdr_q <= {hdr_q[1:0], pin.hostData};
            if (hdrLast) begin
              tgt_q <= hdr_q;
              // a read request or unused code drops the frame
              serSt_q <= (pin.hostData | ~tgtKnown) ? TBC_SER_DROP
                                                    : TBC_SER_PASS;
            end
          end
        end
        TBC_SER_PASS,
        TBC_SER_DROP: if (loadRise) serSt_q <= TBC_SER_IDLE;
        default:      serSt_q <= TBC_SER_IDLE;
      endcase
    end
  end

  // shared wires and per-target strobes; clock waits for a low half
  // so the target never sees the header's last rising edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clkArmed_q         <= 1'h0;
      sharedShiftClkOut  <= 1'h0;
      sharedSerialOut    <= 1'h0;
      tgLoadStrobe       <= 1'h1;
      frontendLoadStrobe <= 2'h3;
      selfShift_q        <= '0;
    end else begin
      clkArmed_q         <= inPass & (clkArmed_q | clkFall);
      sharedShiftClkOut  <= fwd & clkArmed_q & pin.hostClk;
      sharedSerialOut    <= fwd & pin.hostData;
      tgLoadStrobe       <= ~(fwd & (tgt_q == TBC_TGT_TG));
      frontendLoadStrobe <= ~{fwd & (tgt_q == TBC_TGT_FE2),
                              fwd & (tgt_q == TBC_TGT_FE1)};
      if (reinit) selfShift_q <= '0;
      else if (selfBit)
        selfShift_q <= {selfShift_q[TBC_SELF_W-2:0], pin.hostData};
    end
  end

  // timing generator tracking and monitor copies
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      expose_q      <= 1'h0;
      frameCnt_q    <= '0;
      tgForceResetN <= 1'h1;
      frameSyncToTg <= 1'h0;
      pixValidOut   <= 1'h0;
      lineValidOut  <= 1'h0;
      frameValidOut <= 1'h0;
    end else begin
      // readout start ends integration, so it outranks a new start
      if (reinit | frameRise) expose_q <= 1'h0;
      else if (intRise & ready) expose_q <= 1'h1;
      if (reinit) frameCnt_q <= '0;
      else if (frameFall) frameCnt_q <= frameCnt_q + 1'b1;
      tgForceResetN <= ~pin.remoteReinit;
      frameSyncToTg <= ready;
      pixValidOut   <= pin.pixValid;
      lineValidOut  <= pin.lineValid;
      frameValidOut <= pin.frameValid;
    end
  end
  assign exposureActiveOut = expose_q;

  // checks share the system clock and drop out while in reset
  default clocking chkClk @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  AST_FORCE_RESET: assert property (
    pin.remoteReinit |=> !tgForceResetN)
    else $error("force reset not held while remote reinit high");
  AST_BTN_REINIT: assert property (
    btnRise |=> inDelay && tickCnt_q == '0 && delayCnt_q == '0)
    else $error("button edge did not restart initialisation");
  AST_REMOTE_REINIT: assert property (
    remoteFall |=> inDelay ##1 !ready)
    else $error("remote falling edge did not reinitialise");
  AST_TICK_WRAP: assert property (
    tickWrap && !reinit |=> tickCnt_q == '0
    ##1 (tickCnt_q == CW'(1) || $past(reinit)))
    else $error("tick counter did not wrap at its period");
  AST_BIN_WINS: assert property (
    delayDone && !reinit && pin.binSw |=> mode_q == TBC_MODE_BIN && ready)
    else $error("binning switch did not take priority");
  AST_DUAL_MODE: assert property (
    delayDone && !reinit && pin.chanSw && !pin.binSw
    |=> mode_q == TBC_MODE_DUAL)
    else $error("channel switch did not select dual output");
  AST_VALID_COPY: assert property (
    ##1 frameValidOut == $past(pin.frameValid)
    && lineValidOut == $past(pin.lineValid))
    else $error("valid monitor outputs do not follow inputs");
  AST_EXPOSE_SET: assert property (
    intRise && ready && !frameRise && !reinit |=> exposureActiveOut)
    else $error("integration start did not raise exposure output");
  AST_TG_STROBE: assert property (
    inPass && tgt_q == TBC_TGT_TG |=> !tgLoadStrobe
    && frontendLoadStrobe == 2'h3)
    else $error("wrong load strobe for generator target");
  AST_READ_DROP: assert property (
    serSt_q == TBC_SER_HDR && clkRise && hdrLast && pin.hostData
    && !loadRise && !reinit |=> serSt_q == TBC_SER_DROP)
    else $error("read request was not dropped");
  COV_READY: cover property (delayDone ##1 ready);
  COV_TG_WRITE: cover property (
    fwd && tgt_q == TBC_TGT_TG && sharedShiftClkOut);
  COV_EXPOSE: cover property (
    $rose(exposureActiveOut) ##[1:1000] $fell(exposureActiveOut));
endmodule

// >>> include/tbc_pkg.sv
// shared constants and types of the timing board control logic
package tbc_pkg;
  // clock and tick timing
  localparam int TBC_CLK_PERIOD_NS  = 40;
  localparam int TBC_TICK_PERIOD_NS = 1_000_000;
  localparam int TBC_TICK_CYCLES    = TBC_TICK_PERIOD_NS / TBC_CLK_PERIOD_NS;
  localparam int TBC_PWR_DELAY_MS   = 125;
  // serial header: three select bits then the direction bit
  localparam int         TBC_HDR_BITS = 4;
  localparam int         TBC_SELF_W   = 16;
  localparam logic [2:0] TBC_TGT_SELF = 3'h0;
  localparam logic [2:0] TBC_TGT_FE1  = 3'h1;
  localparam logic [2:0] TBC_TGT_FE2  = 3'h2;
  localparam logic [2:0] TBC_TGT_TG   = 3'h3;
  // register map
  localparam logic [7:0] TBC_REG_CTRL   = 8'h00;
  localparam logic [7:0] TBC_REG_STATUS = 8'h04;
  localparam logic [7:0] TBC_REG_SELF   = 8'h08;
  localparam int         TBC_CTRL_REINIT   = 0;
  localparam int         TBC_CTRL_STEER_EN = 1;
  localparam logic       TBC_STEER_EN_RST  = 1'h1;

  typedef enum logic [1:0] {
    TBC_MODE_SINGLE, TBC_MODE_DUAL, TBC_MODE_BIN
  } tbc_mode_t;
  typedef enum logic {TBC_INIT_DELAY, TBC_INIT_READY} tbc_init_t;
  typedef enum logic [1:0] {
    TBC_SER_IDLE, TBC_SER_HDR, TBC_SER_PASS, TBC_SER_DROP
  } tbc_ser_t;

  // all pins that arrive from outside the clock domain
  typedef struct packed {
    logic       boardReset;
    logic       chanSw;
    logic       binSw;
    logic       remoteReinit;
    logic [4:0] expSel;
    logic       hostLoad;
    logic       hostClk;
    logic       hostData;
    logic       pixValid;
    logic       lineValid;
    logic       frameValid;
    logic       intStart;
  } tbc_pins_t;
  localparam tbc_pins_t TBC_PINS_RST = '{hostLoad: 1'h1, default: '0};

  // status word layout, high bits first from the left
  typedef struct packed {
    logic [7:0] frames;
    logic [6:0] rsvd;
    logic       expose;
    logic       ready;
    logic [4:0] expSel;
    tbc_mode_t  mode;
  } tbc_status_t;
endpackage

// >>> logic/tbc_sync.sv
// three-stage input synchroniser that accepts a change once stages agree
`timescale 1ns/100ps
module tbc_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      dout
);
  logic [W-1:0] meta1_q;
  logic [W-1:0] meta2_q;
  logic [W-1:0] meta3_q;
  logic [W-1:0] out_q;
  wire  [W-1:0] agree = ~(meta2_q ^ meta3_q);

  // meta1 feeds only meta2; bits update only where stages 2 and 3 agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta1_q <= RST_VAL;
      meta2_q <= RST_VAL;
      meta3_q <= RST_VAL;
      out_q   <= RST_VAL;
    end else begin
      meta1_q <= din;
      meta2_q <= meta1_q;
      meta3_q <= meta2_q;
      out_q   <= (out_q & ~agree) | (meta3_q & agree);
    end
  end
  assign dout = out_q;
endmodule

// >>> sim/tbc_host_model.sv
// host serial controller and timing generator stand-in for the bench
`timescale 1ns/100ps
module tbc_host_model (
  output logic hostLoadIn,
  output logic hostShiftClkIn,
  output logic hostSerialIn,
  output logic tgPixValidIn,
  output logic tgLineValidIn,
  output logic tgFrameValidIn,
  output logic tgIntStartIn
);
  localparam int HALF_NS = 160;

  // idle link: load high, clock parked low, generator quiet
  initial begin
    hostLoadIn     = 1'h1;
    hostShiftClkIn = 1'h0;
    hostSerialIn   = 1'h0;
    {tgIntStartIn, tgFrameValidIn, tgLineValidIn, tgPixValidIn} = 4'h0;
  end

  // one frame: select, direction, 16 payload bits, all msb first;
  // the clock runs only inside the frame, so the block cannot lean on it
  task automatic send(input logic [2:0] sel, input logic rw,
                      input logic [15:0] pay);
    logic [19:0] bits;
    bits = {sel, rw, pay};
    #37 hostLoadIn = 1'h0;
    // clock low while the bit changes, high half later: one rise per bit
    for (int i = 19; i >= 0; i--) begin
      #HALF_NS hostShiftClkIn = 1'h0;
      hostSerialIn = bits[i];
      #HALF_NS hostShiftClkIn = 1'h1;
    end
    #HALF_NS hostShiftClkIn = 1'h0;
    #HALF_NS hostLoadIn = 1'h1;
    // no pull on the data line, so it shows the inverse once released
    hostSerialIn = ~hostSerialIn;
  endtask

  // generator levels: int start, frame, line, pixel valid
  task automatic set_gen(input logic [3:0] v);
    {tgIntStartIn, tgFrameValidIn, tgLineValidIn, tgPixValidIn} <= v;
  endtask
endmodule

// >>> sim/tbc_board_ctrl_tb.sv
// self-checking bench: apb tasks, serial frames, reinit and pin checks
`timescale 1ns/100ps
module tbc_board_ctrl_tb;
  import tbc_pkg::*;
  localparam int TICKS    = 20;
  localparam int DELAY    = 3;
  localparam int WAIT_MAX = 200;

  logic        clock, rst_n, boardResetBtn, channelCountSwitch;
  logic        binningSwitch, remoteReinitIn, hostLoadIn, hostShiftClkIn;
  logic        hostSerialIn, tgPixValidIn, tgLineValidIn, tgFrameValidIn;
  logic        tgIntStartIn, psel, penable, pwrite, pready, pslverr;
  logic        tgForceResetN, exposureTickOut, exposureActiveOut, monClr;
  logic        pixValidOut, lineValidOut, frameValidOut, frameSyncToTg;
  logic        sharedShiftClkOut, sharedSerialOut, tgLoadStrobe, prevSclk;
  logic [1:0]  frontendLoadStrobe;
  logic [2:0]  seenLow;
  logic [7:0]  paddr;
  logic [15:0] remoteDio, shiftCap;
  logic [31:0] pwdata, prdata;
  int          err_total, cmp_count, clkCnt;
  tbc_status_t st;
  logic [15:0] dioTab [3] = '{16'h0000, 16'hFAFF, 16'h0580};
  logic [2:0]  vTab [4]   = '{3'h1, 3'h2, 3'h4, 3'h0};

  tbc_board_ctrl #(.TICK_CYCLES(TICKS), .DELAY_TICKS(DELAY))
    i_tbc_board_ctrl (
    .clock(clock), .rst_n(rst_n), .boardResetBtn(boardResetBtn),
    .channelCountSwitch(channelCountSwitch), .binningSwitch(binningSwitch),
    .remoteReinitIn(remoteReinitIn), .remoteDio(remoteDio),
    .hostLoadIn(hostLoadIn), .hostShiftClkIn(hostShiftClkIn),
    .hostSerialIn(hostSerialIn), .tgPixValidIn(tgPixValidIn),
    .tgLineValidIn(tgLineValidIn), .tgFrameValidIn(tgFrameValidIn),
    .tgIntStartIn(tgIntStartIn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tgForceResetN(tgForceResetN),
    .exposureTickOut(exposureTickOut),
    .exposureActiveOut(exposureActiveOut), .pixValidOut(pixValidOut),
    .lineValidOut(lineValidOut), .frameValidOut(frameValidOut),
    .frameSyncToTg(frameSyncToTg), .sharedShiftClkOut(sharedShiftClkOut),
    .sharedSerialOut(sharedSerialOut), .tgLoadStrobe(tgLoadStrobe),
    .frontendLoadStrobe(frontendLoadStrobe));
  tbc_host_model i_tbc_host_model (
    .hostLoadIn(hostLoadIn), .hostShiftClkIn(hostShiftClkIn),
    .hostSerialIn(hostSerialIn), .tgPixValidIn(tgPixValidIn),
    .tgLineValidIn(tgLineValidIn), .tgFrameValidIn(tgFrameValidIn),
    .tgIntStartIn(tgIntStartIn));

  // watch the forwarded link: clock rises, captured bits, strobes seen low
  always @(posedge clock) begin
    prevSclk <= sharedShiftClkOut;
    if (monClr) begin
      clkCnt   <= 0;
      seenLow  <= 3'h0;
      shiftCap <= 16'h0000;
    end else begin
      seenLow <= seenLow | ~{tgLoadStrobe, frontendLoadStrobe};
      if (sharedShiftClkOut === 1'h1 && prevSclk === 1'h0) begin
        clkCnt   <= clkCnt + 1;
        shiftCap <= {shiftCap[14:0], sharedSerialOut};
      end
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one apb transfer; pready is taken at the rising edge where it stands,
  // with data and error, and only then is the request released
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] expD,
                     input logic expE);
    int          n;
    logic [31:0] r;
    logic        e;
    n = 0;
    @(posedge clock);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 40);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    chk(32'(n < 40), 32'h0000_0001);
    if (!w) chk(r, expD);
    chk(32'(e), 32'(expE));
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (frameSyncToTg !== 1'h1 && n < WAIT_MAX) begin
      @(negedge clock);
      n++;
    end
    chk(32'(n < WAIT_MAX), 32'h0000_0001);
  endtask

  // how: 0 pushbutton rise, 1 remote line pulse, 2 soft reinit bit
  task automatic reinit(input int how);
    @(posedge clock);
    if (how == 0) boardResetBtn <= 1'h1;
    if (how == 1) remoteReinitIn <= 1'h1;
    if (how == 2) apb(1'h1, TBC_REG_CTRL, 32'h0000_0003, 32'h0, 1'h0);
    repeat (10) @(posedge clock);
    if (how == 1) chk(32'(tgForceResetN), 32'h0000_0000);
    boardResetBtn  <= 1'h0;
    remoteReinitIn <= 1'h0;
    repeat (10) @(posedge clock);
    chk(32'(tgForceResetN), 32'h0000_0001);
    chk(32'(frameSyncToTg), 32'h0000_0000);
    wait_ready();
  endtask

  task automatic gen(input logic [3:0] v);
    i_tbc_host_model.set_gen(v);
    repeat (8) @(negedge clock);
  endtask

  // one frame on the host link and what reached the shared outputs
  task automatic frame_chk(input logic [2:0] sel, input logic rw,
                           input logic [15:0] pay, input logic live);
    logic [2:0] expLow;
    expLow = live ? 3'(1 << (sel - 3'h1)) : 3'h0;
    @(posedge clock);
    monClr <= 1'h1;
    @(posedge clock);
    monClr <= 1'h0;
    i_tbc_host_model.send(sel, rw, pay);
    repeat (12) @(posedge clock);
    chk(32'(seenLow), 32'(expLow));
    chk(32'(clkCnt), live ? 32'h0000_0010 : 32'h0);
    if (live) chk(32'(shiftCap), 32'(pay));
    chk(32'({tgLoadStrobe, frontendLoadStrobe}), 32'h0000_0007);
  endtask

  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  // hang guard, far above the few thousand cycles the tests need
  initial begin
    repeat (12000) @(posedge clock);
    err_total++;
    end_of_test();
  end

  initial begin
    int hi;
    int lo;
    int n;
    {rst_n, boardResetBtn, channelCountSwitch, binningSwitch} = 4'h0;
    {psel, penable, pwrite, remoteReinitIn, monClr} = 5'h01;
    remoteDio = 16'h0000;
    paddr     = 8'h00;
    pwdata    = 32'h0000_0000;
    repeat (3) @(posedge clock);
    chk(32'({tgForceResetN, tgLoadStrobe, frontendLoadStrobe,
             frameSyncToTg, pready}), 32'h0000_003C);
    repeat (3) @(posedge clock);
    rst_n  <= 1'h1;
    monClr <= 1'h0;
    // register map before the startup delay ends, with refused accesses
    apb(1'h0, TBC_REG_CTRL, 32'h0, 32'h0000_0002, 1'h0);
    apb(1'h1, TBC_REG_SELF, 32'hFFFF_FFFF, 32'h0, 1'h0);
    apb(1'h0, TBC_REG_SELF, 32'h0, 32'h0000_0000, 1'h0);
    apb(1'h0, 8'h0C, 32'h0, 32'h0000_0000, 1'h1);
    apb(1'h1, 8'h40, 32'h1234_5678, 32'h0, 1'h1);
    wait_ready();
    // tick shape: high for the first half of its period
    {hi, lo, n} = '0;
    while (exposureTickOut !== 1'h0 && n < 100) begin
      @(negedge clock);
      n++;
    end
    while (exposureTickOut !== 1'h1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    while (exposureTickOut === 1'h1 && n < 100) begin
      @(negedge clock);
      hi++;
      n++;
    end
    while (exposureTickOut === 1'h0 && n < 100) begin
      @(negedge clock);
      lo++;
      n++;
    end
    chk(32'(hi), 32'(TICKS / 2));
    chk(32'(hi + lo), 32'(TICKS));
    // each readout mode taken in through a different reinit route
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      channelCountSwitch <= 1'(i > 0);
      binningSwitch      <= 1'(i == 2);
      remoteDio          <= dioTab[i];
      reinit(i);
      st = '{8'h00, 7'h00, 1'h0, 1'h1, dioTab[i][11:7], tbc_mode_t'(2'(i))};
      apb(1'h0, TBC_REG_STATUS, 32'h0, 32'(st), 1'h0);
    end
    // valids copied; exposure from int start up to frame valid rise
    foreach (vTab[k]) begin
      gen({1'h0, vTab[k]});
      chk(32'({frameValidOut, lineValidOut, pixValidOut}),
          32'(vTab[k]));
    end
    gen(4'h8);
    chk(32'(exposureActiveOut), 32'h0000_0001);
    gen(4'h0);
    chk(32'(exposureActiveOut), 32'h0000_0001);
    gen(4'h4);
    chk(32'(exposureActiveOut), 32'h0000_0000);
    gen(4'h0);
    st = '{8'h02, 7'h00, 1'h0, 1'h1, 5'h0B, TBC_MODE_BIN};
    apb(1'h0, TBC_REG_STATUS, 32'h0, {8'h00, st}, 1'h0);
    // steering: self register, a refused read, three targets, then refused frames
    i_tbc_host_model.send(TBC_TGT_SELF, 1'h0, 16'hA5C3);
    repeat (10) @(posedge clock);
    apb(1'h0, TBC_REG_SELF, 32'h0, 32'h0000_A5C3, 1'h0);
    for (int k = 0; k < 8; k++) begin
      frame_chk(k == 0 ? TBC_TGT_TG : 3'(k), 1'(k == 0),
                16'h1234 ^ 16'(k * 4369), 1'(k > 0 && k < 4));
    end
    apb(1'h1, TBC_REG_CTRL, 32'h0000_0000, 32'h0, 1'h0);
    apb(1'h0, TBC_REG_CTRL, 32'h0, 32'h0000_0000, 1'h0);
    frame_chk(TBC_TGT_FE1, 1'h0, 16'h5A5A, 1'h0);
    end_of_test();
  end
endmodule
